/* hw/wrc_top.sv */
// Behaviour
// - Watchdog overflow outside sleep resets the device; clear instruction restarts the count.
// - Enable key 10101B disables the watchdog.
// - Enable key 01010B enables and runs the watchdog.
// - Any other key value resets the device after 2~3 slow RC cycles.
// - The enable key powers up as the enable code.
// - Time-out in normal or slow mode gives a full reset and sets the time-out flag.
// - Time-out in sleep or idle sets the flag and clears only PC and SP.
// - Count cleared by invalid key write, clear instruction or halt.
// - Division ratio runs from 2^8 to 2^18 sub clock periods.
// - Power-on reset sets the program counter to zero.
// - Power-on reset presets port data and direction to all ones.
// - After power-on or low-voltage release, reset holds for 50 ms.
// - Low-voltage reset always on in active modes and sets its flag.
// - A low-supply indication trips a reset only after the filter time but restarts a hold's release delay at once.
// - Level select decodes four codes into four thresholds.
// - Invalid level select resets after 2~3 slow cycles and restores it.
// - Invalid level select reset sets the level fault flag.
// - A genuine low-voltage reset keeps the level select contents.
// - Level select powers up as 01010101B.
// - Low-voltage reset is disabled in idle or sleep.
// - Normal time-out reset equals low-voltage reset apart from setting the time-out flag instead of the low-voltage flag, and a shorter hold.
// - Normal time-out reset holds the device for 16.7 ms.
// - Watchdog counts the sub clock from slow RC or 32.768 kHz crystal.
// - Three-bit select maps 000..111 to 2^8,10,12,14,15,16,17,18.
// - A corrupted enable key reset sets the watchdog fault flag.
// - Power-on clears time-out and power-down flags; sleep time-out leaves both set.
`timescale 1ns/1ps
`default_nettype none
module wrc_top #(
   parameter int unsigned POR_DELAY = wrc_pkg::POR_DELAY_CYC,
   parameter int unsigned WDT_DELAY = wrc_pkg::WDT_DELAY_CYC,
   parameter int unsigned LV_FILTER = wrc_pkg::LV_FILTER_CYC,
   parameter int unsigned RC_DIVIDE = wrc_pkg::RC_DIV,
   parameter int unsigned XTAL_DIVIDE = wrc_pkg::XTAL_DIV
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire wrc_pkg::wrc_wb_req_t wb_req_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic clear_watchdog_instr_i,
   input wire logic halt_i,
   input wire logic sleep_mode_i,
   input wire logic sub_src_xtal_i,
   input wire logic low_supply_i,
   output logic cpu_reset_o,
   output logic port_preset_o,
   output logic pc_sp_clear_o,
   output logic [1:0] lowv_threshold_o,
   output logic idle_sysclk_keep_o
);
   import wrc_pkg::*;

   // ----------------------------------------------------------------
   // Slow clock enables.
   // ----------------------------------------------------------------
   localparam int unsigned DIV_W = 12;
   logic [DIV_W-1:0] div_cnt [2];
   logic [DIV_W-1:0] next_div_cnt [2];
   logic [1:0] div_tick;
   logic [DIV_W-1:0] div_last [2];

   assign div_last[0] = DIV_W'(RC_DIVIDE - 1);
   assign div_last[1] = DIV_W'(XTAL_DIVIDE - 1);

   // One divider per slow source; each emits a one-cycle tick per slow period.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_div
         always_comb begin
            div_tick[gi] = (div_cnt[gi] == div_last[gi]);
            next_div_cnt[gi] = div_tick[gi] ? '0 : div_cnt[gi] + DIV_W'(1);
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               div_cnt[gi] <= '0;
            end else begin
               div_cnt[gi] <= next_div_cnt[gi];
            end
         end
      end
   endgenerate

   logic rc_tick;
   logic sub_tick;
   assign rc_tick = div_tick[0];
   assign sub_tick = sub_src_xtal_i ? div_tick[1] : div_tick[0];

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   wrc_state_t state, next_state;
   wrc_cause_t cause, next_cause;
   logic [DLY_W-1:0] dly_cnt, next_dly_cnt;
   logic [WDT_W-1:0] wdt_cnt, next_wdt_cnt;
   logic [7:0] wdt_ctrl, next_wdt_ctrl;
   logic [7:0] lvl_sel, next_lvl_sel;
   logic [3:0] flags, next_flags;
   logic to_flag, next_to_flag;
   logic pd_flag, next_pd_flag;
   logic [DLY_W-1:0] lv_cnt, next_lv_cnt;
   logic [1:0] flt_cnt, next_flt_cnt;
   logic ack, next_ack;
   logic [31:0] rdat, next_rdat;
   logic pcsp, next_pcsp;

   logic [4:0] key;
   logic [2:0] lvl_dec;
   logic key_bad;
   logic wdt_run;
   logic bus_req;
   logic wr_ok;
   logic lv_active;
   logic lv_trip;
   logic flt_trip;
   logic overflow;
   logic [2:0] flag_clr;
   logic [2:0] flag_set;

   // Decoded views of the control registers.
   always_comb begin
      key = wdt_ctrl[KEY_MSB:KEY_LSB];
      lvl_dec = wrc_level_decode(lvl_sel);
      key_bad = (key != KEY_ENABLE) && (key != KEY_DISABLE);
      wdt_run = (state == ST_RUN) && (key == KEY_ENABLE);
      bus_req = wb_req_i.cyc && wb_req_i.stb && !ack;
      wr_ok = bus_req && wb_req_i.we && wb_req_i.sel[0] && (state == ST_RUN);
      lv_active = low_supply_i && !sleep_mode_i;
      lv_trip = lv_active && (lv_cnt >= DLY_W'(LV_FILTER));
      flt_trip = rc_tick && (flt_cnt == FAULT_TICKS - 2'h1);
      overflow = wdt_run && sub_tick && (wdt_cnt >= wrc_ratio_last(wdt_ctrl[RATIO_MSB:0]));
   end

   // Main next-state logic: resets, watchdog, filters and register bus.
   always_comb begin
      next_state = state;
      next_cause = cause;
      next_dly_cnt = dly_cnt;
      next_wdt_cnt = wdt_cnt;
      next_wdt_ctrl = wdt_ctrl;
      next_lvl_sel = lvl_sel;
      next_to_flag = to_flag;
      next_pd_flag = pd_flag;
      next_lv_cnt = lv_active ? lv_cnt + DLY_W'(1) : '0;
      next_flt_cnt = flt_cnt;
      next_ack = bus_req;
      next_rdat = '0;
      next_pcsp = 1'b0;
      flag_clr = '0;
      flag_set = '0;
      next_flags = flags;

      // Low-supply filter counter saturates at the threshold.
      if (lv_cnt >= DLY_W'(LV_FILTER)) begin
         next_lv_cnt = lv_active ? lv_cnt : '0;
      end

      // Corruption timer counts slow RC edges while any key or level is bad.
      if (key_bad || !lvl_dec[2]) begin
         if (rc_tick) begin
            next_flt_cnt = flt_cnt + 2'h1;
         end
      end else begin
         next_flt_cnt = '0;
      end

      // Watchdog count on the sub clock enable.
      if (wdt_run && sub_tick) begin
         next_wdt_cnt = overflow ? '0 : wdt_cnt + WDT_W'(1);
      end

      // Core instructions: both clear the count; halt marks power-down.
      if (clear_watchdog_instr_i) begin
         next_wdt_cnt = '0;
         next_pd_flag = 1'b0;
      end
      if (halt_i) begin
         next_wdt_cnt = '0;
         next_pd_flag = 1'b1;
      end

      // Register reads.
      if (bus_req && !wb_req_i.we) begin
         if (wb_req_i.adr == OFS_WDT_CTRL) begin
            next_rdat = {24'h000000, wdt_ctrl};
         end else if (wb_req_i.adr == OFS_LVL_SEL) begin
            next_rdat = {24'h000000, lvl_sel};
         end else if (wb_req_i.adr == OFS_FLAGS) begin
            next_rdat = {24'h000000, flags[3], 4'h0, flags[2:0]};
         end else if (wb_req_i.adr == OFS_STATUS) begin
            next_rdat = {26'h0000000, lvl_dec[1:0], (state == ST_HOLD), wdt_run,
                         pd_flag, to_flag};
         end
      end

      // Register writes; refused while the device is held in reset.
      if (wr_ok) begin
         if (wb_req_i.adr == OFS_WDT_CTRL) begin
            next_wdt_ctrl = wb_req_i.dat[7:0];
            if ((wb_req_i.dat[KEY_MSB:KEY_LSB] != KEY_ENABLE)
                && (wb_req_i.dat[KEY_MSB:KEY_LSB] != KEY_DISABLE)) begin
               next_wdt_cnt = '0;
            end
         end else if (wb_req_i.adr == OFS_LVL_SEL) begin
            next_lvl_sel = wb_req_i.dat[7:0];
         end else if (wb_req_i.adr == OFS_FLAGS) begin
            next_flags[3] = wb_req_i.dat[FLG_SYSCLK];
            flag_clr = ~wb_req_i.dat[FLG_LOWV:FLG_KEYF];
         end
      end

      // Reset sequencing.
      case (state)
         ST_RUN: begin
            if (lv_trip) begin
               next_state = ST_HOLD;
               next_cause = CAUSE_LOWV;
               flag_set[FLG_LOWV] = 1'b1;
            end else if (flt_trip && key_bad) begin
               next_state = ST_HOLD;
               next_cause = CAUSE_KEY;
               flag_set[FLG_KEYF] = 1'b1;
            end else if (flt_trip && !lvl_dec[2]) begin
               next_state = ST_HOLD;
               next_cause = CAUSE_LVL;
               flag_set[FLG_LVLF] = 1'b1;
            end else if (overflow && sleep_mode_i) begin
               next_to_flag = 1'b1;
               next_pcsp = 1'b1;
            end else if (overflow) begin
               next_state = ST_HOLD;
               next_cause = CAUSE_WDT;
               next_to_flag = 1'b1;
            end
            if (next_state == ST_HOLD) begin
               next_wdt_cnt = '0;
               next_wdt_ctrl = WDT_CTRL_RESET;
               next_flt_cnt = '0;
               next_dly_cnt = (next_cause == CAUSE_WDT) ? DLY_W'(WDT_DELAY)
                                                        : DLY_W'(POR_DELAY);
               if (next_cause == CAUSE_LVL) begin
                  next_lvl_sel = LVL_SEL_RESET;
               end
            end
         end
         default: begin
            // Hold timer; a persisting low supply restarts the release delay.
            next_wdt_cnt = '0;
            if (lv_active) begin
               next_dly_cnt = DLY_W'(POR_DELAY);
            end else if (dly_cnt == '0) begin
               next_state = ST_RUN;
            end else begin
               next_dly_cnt = dly_cnt - DLY_W'(1);
            end
         end
      endcase

      // Hardware set wins over a software clear.
      next_flags[2:0] = (flags[2:0] & ~flag_clr) | flag_set;
   end

   // State registers; power-on values on rst_i.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_HOLD;
         cause <= CAUSE_POR;
         dly_cnt <= DLY_W'(POR_DELAY);
         wdt_cnt <= '0;
         wdt_ctrl <= WDT_CTRL_RESET;
         lvl_sel <= LVL_SEL_RESET;
         flags <= '0;
         to_flag <= 1'b0;
         pd_flag <= 1'b0;
         lv_cnt <= '0;
         flt_cnt <= '0;
         ack <= 1'b0;
         rdat <= '0;
         pcsp <= 1'b0;
      end else begin
         state <= next_state;
         cause <= next_cause;
         dly_cnt <= next_dly_cnt;
         wdt_cnt <= next_wdt_cnt;
         wdt_ctrl <= next_wdt_ctrl;
         lvl_sel <= next_lvl_sel;
         flags <= next_flags;
         to_flag <= next_to_flag;
         pd_flag <= next_pd_flag;
         lv_cnt <= next_lv_cnt;
         flt_cnt <= next_flt_cnt;
         ack <= next_ack;
         rdat <= next_rdat;
         pcsp <= next_pcsp;
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   // While held, the core sees reset: PC to zero, ports preset to inputs.
   assign cpu_reset_o = rst_i || (state == ST_HOLD);
   assign port_preset_o = rst_i || (state == ST_HOLD);
   assign pc_sp_clear_o = pcsp;
   assign lowv_threshold_o = lvl_dec[1:0];
   assign idle_sysclk_keep_o = flags[3];
   assign wb_ack_o = ack;
   assign wb_dat_o = rdat;

endmodule // wrc_top
`default_nettype wire

/* pkg/wrc_pkg.sv */
`default_nettype none
package wrc_pkg;

   // ----------------------------------------------------------------
   // Clock and timing.
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned RC_PERIOD_PS = 31_250_000;
   localparam int unsigned XTAL_PERIOD_PS = 30_517_578;
   localparam int unsigned RC_DIV = RC_PERIOD_PS / (CLK_PERIOD_NS * 1000);
   localparam int unsigned XTAL_DIV = XTAL_PERIOD_PS / (CLK_PERIOD_NS * 1000);
   localparam int unsigned POR_DELAY_NS = 50_000_000;
   localparam int unsigned POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS;
   localparam int unsigned WDT_DELAY_NS = 16_700_000;
   localparam int unsigned WDT_DELAY_CYC = WDT_DELAY_NS / CLK_PERIOD_NS;
   localparam int unsigned LV_FILTER_NS = 1_000;
   localparam int unsigned LV_FILTER_CYC = (LV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] FAULT_TICKS = 2'h3;
   localparam int unsigned DLY_W = 23;
   localparam int unsigned WDT_W = 18;

   // ----------------------------------------------------------------
   // Register map (byte addresses) and field layout.
   // ----------------------------------------------------------------
   localparam int unsigned ADR_W = 8;
   localparam logic [ADR_W-1:0] OFS_WDT_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] OFS_LVL_SEL = 8'h04;
   localparam logic [ADR_W-1:0] OFS_FLAGS = 8'h08;
   localparam logic [ADR_W-1:0] OFS_STATUS = 8'h0C;
   localparam int unsigned KEY_MSB = 7;
   localparam int unsigned KEY_LSB = 3;
   localparam int unsigned RATIO_MSB = 2;
   localparam logic [4:0] KEY_ENABLE = 5'h0A;
   localparam logic [4:0] KEY_DISABLE = 5'h15;
   localparam logic [7:0] WDT_CTRL_RESET = 8'h53;
   localparam logic [7:0] LVL_SEL_RESET = 8'h55;
   localparam logic [7:0] LVL_CODE_2V10 = 8'h55;
   localparam logic [7:0] LVL_CODE_2V55 = 8'h33;
   localparam logic [7:0] LVL_CODE_3V15 = 8'h99;
   localparam logic [7:0] LVL_CODE_3V80 = 8'hAA;
   localparam int unsigned FLG_SYSCLK = 7;
   localparam int unsigned FLG_LOWV = 2;
   localparam int unsigned FLG_LVLF = 1;
   localparam int unsigned FLG_KEYF = 0;
   localparam int unsigned STS_TMO = 0;
   localparam int unsigned STS_PD = 1;
   localparam int unsigned STS_RUN = 2;
   localparam int unsigned STS_HOLD = 3;
   localparam int unsigned STS_THR_LSB = 4;

   // ----------------------------------------------------------------
   // Types.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [ADR_W-1:0] adr;
      logic [31:0] dat;
   } wrc_wb_req_t;

   typedef enum logic [2:0] {CAUSE_POR, CAUSE_LOWV, CAUSE_WDT, CAUSE_KEY, CAUSE_LVL} wrc_cause_t;
   typedef enum logic {ST_HOLD, ST_RUN} wrc_state_t;

   // Last count before overflow for a time-out ratio select code.
   function automatic logic [WDT_W-1:0] wrc_ratio_last(input logic [2:0] sel);
      logic [WDT_W-1:0] r;
      r = '0;
      case (sel)
         3'h0: r = 18'h000FF;
         3'h1: r = 18'h003FF;
         3'h2: r = 18'h00FFF;
         3'h3: r = 18'h03FFF;
         3'h4: r = 18'h07FFF;
         3'h5: r = 18'h0FFFF;
         3'h6: r = 18'h1FFFF;
         default: r = 18'h3FFFF;
      endcase
      return r;
   endfunction

   // Level select decode: valid bit and threshold index.
   function automatic logic [2:0] wrc_level_decode(input logic [7:0] code);
      logic [2:0] d;
      d = 3'h0;
      if (code == LVL_CODE_2V10) d = 3'h4;
      else if (code == LVL_CODE_2V55) d = 3'h5;
      else if (code == LVL_CODE_3V15) d = 3'h6;
      else if (code == LVL_CODE_3V80) d = 3'h7;
      return d;
   endfunction

endpackage
`default_nettype wire

/* tb/wrc_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the watchdog and reset controller.
// ----------------------------------------------------------------
module wrc_top_sva #(
   parameter int unsigned POR_DELAY = 50,
   parameter int unsigned LV_FILTER = 100,
   parameter int unsigned RC_DIVIDE = 3125
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire wrc_pkg::wrc_wb_req_t wb_req_i,
   input wire logic wb_ack_o,
   input wire logic sleep_mode_i,
   input wire logic low_supply_i,
   input wire logic cpu_reset_o,
   input wire logic port_preset_o,
   input wire logic pc_sp_clear_o,
   input wire logic [1:0] lowv_threshold_o
);
   import wrc_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   int unsigned rel_cnt;
   int unsigned lv_cnt;
   int unsigned flt_cnt;
   logic flt_pend;
   logic wr_ack;
   logic flt_wr;
   // A write accepted while the core runs, and whether it corrupts a keyed field.
   assign wr_ack = wb_ack_o && wb_req_i.we && wb_req_i.sel[0] && !cpu_reset_o;
   assign flt_wr = wr_ack && ((wb_req_i.adr == OFS_WDT_CTRL
      && !(wb_req_i.dat[7:3] inside {KEY_ENABLE, KEY_DISABLE})) || (wb_req_i.adr == OFS_LVL_SEL
      && !(wb_req_i.dat[7:0] inside {LVL_CODE_2V10, LVL_CODE_2V55, LVL_CODE_3V15,
      LVL_CODE_3V80})));
   // Counts cycles since release, low-supply run length and the wait after a fault.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rel_cnt <= 0;
         lv_cnt <= 0;
         flt_pend <= 1'b0;
         flt_cnt <= 0;
      end else begin
         if (rel_cnt < POR_DELAY) rel_cnt <= rel_cnt + 1;
         if (!low_supply_i || sleep_mode_i) lv_cnt <= 0;
         else if (lv_cnt < LV_FILTER + 3) lv_cnt <= lv_cnt + 1;
         if (flt_wr) flt_pend <= 1'b1;
         else if (cpu_reset_o) flt_pend <= 1'b0;
         if (flt_wr) flt_cnt <= 0;
         else if (flt_pend) flt_cnt <= flt_cnt + 1;
      end
   end
   sequence s_take;
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack;
      s_take |=> s_ack_pulse;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer missing or too long");
   property p_por_hold;
      rel_cnt < POR_DELAY |-> cpu_reset_o;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("reset hold too short");
   property p_preset;
      port_preset_o == cpu_reset_o;
   endproperty
   a_preset: assert property (p_preset) else $error("port preset differs");
   property p_rst_out;
      disable iff (1'b0) rst_i |-> cpu_reset_o && port_preset_o;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("core not held in reset");
   property p_pcsp;
      pc_sp_clear_o |-> !cpu_reset_o ##1 !pc_sp_clear_o;
   endproperty
   a_pcsp: assert property (p_pcsp) else $error("sleep time-out pulse wrong");
   property p_flt_early;
      flt_pend && flt_cnt < RC_DIVIDE |-> !cpu_reset_o;
   endproperty
   a_flt_early: assert property (p_flt_early) else $error("fault reset too early");
   property p_flt_late;
      flt_pend |-> flt_cnt <= 3 * RC_DIVIDE + 4;
   endproperty
   a_flt_late: assert property (p_flt_late) else $error("fault reset too late");
   property p_lv_act;
      lv_cnt == LV_FILTER + 3 |-> cpu_reset_o;
   endproperty
   a_lv_act: assert property (p_lv_act) else $error("low supply ignored");
   property p_thr;
      wr_ack && wb_req_i.adr == OFS_LVL_SEL && wb_req_i.dat[7:0] == LVL_CODE_3V80
         |-> ##[1:2] lowv_threshold_o == 2'h3;
   endproperty
   a_thr: assert property (p_thr) else $error("threshold decode wrong");
endmodule // wrc_top_sva
bind wrc_top wrc_top_sva #(.POR_DELAY(POR_DELAY), .LV_FILTER(LV_FILTER),
   .RC_DIVIDE(RC_DIVIDE)) wrc_top_sva_i (.clk_i(clk_i), .rst_i(rst_i),
   .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .sleep_mode_i(sleep_mode_i),
   .low_supply_i(low_supply_i), .cpu_reset_o(cpu_reset_o), .port_preset_o(port_preset_o),
   .pc_sp_clear_o(pc_sp_clear_o), .lowv_threshold_o(lowv_threshold_o));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wrc_pkg::*;
   localparam int POR = 50;
   localparam int WDD = 20;
   localparam int LVF = 10;
   localparam int RCD = 8;
   localparam int XTD = 6;
   logic clk_i, rst_i, clear_watchdog_instr_i, halt_i, sleep_mode_i, sub_src_xtal_i, low_supply_i;
   logic wb_ack_o, cpu_reset_o, port_preset_o, pc_sp_clear_o, idle_sysclk_keep_o;
   logic [31:0] wb_dat_o, rd;
   logic [1:0] lowv_threshold_o;
   logic [7:0] codes [4] = '{LVL_CODE_2V10, LVL_CODE_2V55, LVL_CODE_3V15, LVL_CODE_3V80};
   wrc_wb_req_t wb_req_i;
   int n_fail, comparisons, n;
   wrc_top #(.POR_DELAY(POR), .WDT_DELAY(WDD), .LV_FILTER(LVF), .RC_DIVIDE(RCD),
      .XTAL_DIVIDE(XTD)) wrc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .clear_watchdog_instr_i(clear_watchdog_instr_i), .halt_i(halt_i),
      .sleep_mode_i(sleep_mode_i), .sub_src_xtal_i(sub_src_xtal_i),
      .low_supply_i(low_supply_i), .cpu_reset_o(cpu_reset_o),
      .port_preset_o(port_preset_o), .pc_sp_clear_o(pc_sp_clear_o),
      .lowv_threshold_o(lowv_threshold_o), .idle_sysclk_keep_o(idle_sysclk_keep_o));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic bus cycle, held until ack is seen at a rising edge.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
      wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: {24'h0, wd}};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_req_i <= '0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 8'h00);
      chk(rd, exp);
   endtask
   task automatic pulse(input logic hlt);
      clear_watchdog_instr_i <= !hlt;
      halt_i <= hlt;
      @(posedge clk_i);
      clear_watchdog_instr_i <= 1'b0;
      halt_i <= 1'b0;
   endtask
   // Counts edges until the core reset reaches the wanted level, up to a limit.
   task automatic wait_lvl(input logic lvl, input int lim);
      n = 0;
      while (cpu_reset_o !== lvl && n < lim) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Free-running 100 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Cuts a hung run short.
   initial begin
      #400_000;
      n_fail++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      {rst_i, wb_req_i, clear_watchdog_instr_i, halt_i, sleep_mode_i, sub_src_xtal_i, low_supply_i} = '0;
      rst_i = 1'b1;
      n_fail = 0;
      comparisons = 0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wait_lvl(1'b0, 200);
      chk(n >= POR && n <= POR + 2, 1);
      rdc(OFS_WDT_CTRL, 8'h53);
      rdc(OFS_LVL_SEL, 8'h55);
      rdc(OFS_FLAGS, 8'h00);
      rdc(OFS_STATUS, 8'h04);
      rdc(8'h10, 8'h00);
      foreach (codes[i]) begin
         wb(1'b1, OFS_LVL_SEL, codes[i]);
         rdc(OFS_LVL_SEL, codes[i]);
         chk(lowv_threshold_o, i);
      end
      wb(1'b1, OFS_WDT_CTRL, {KEY_DISABLE, 3'h0});
      wait_lvl(1'b1, 3000);
      chk(n, 3000);
      rdc(OFS_STATUS, 8'h30);
      wb(1'b1, OFS_WDT_CTRL, {KEY_ENABLE, 3'h0});
      pulse(1'b0);
      rdc(OFS_STATUS, 8'h34);
      repeat (3) begin
         wait_lvl(1'b1, 1500);
         chk(n, 1500);
         pulse(1'b0);
      end
      pulse(1'b1);
      rdc(OFS_STATUS, 8'h36);
      wait_lvl(1'b1, 1500);
      chk(n, 1500);
      pulse(1'b0);
      wait_lvl(1'b1, 3000);
      chk(n >= 254 * RCD && n <= 257 * RCD, 1);
      wait_lvl(1'b0, 100);
      chk(n >= WDD && n <= WDD + 2, 1);
      rdc(OFS_STATUS, 8'h35);
      rdc(OFS_LVL_SEL, LVL_CODE_3V80);
      wb(1'b1, OFS_WDT_CTRL, {KEY_ENABLE, 3'h1});
      sub_src_xtal_i <= 1'b1;
      pulse(1'b1);
      sleep_mode_i <= 1'b1;
      low_supply_i <= 1'b1;
      n = 0;
      while (pc_sp_clear_o !== 1'b1 && n < 9000) begin
         @(posedge clk_i);
         n++;
      end
      chk(n >= 1022 * XTD && n <= 1025 * XTD, 1);
      chk(cpu_reset_o, 0);
      {low_supply_i, sleep_mode_i, sub_src_xtal_i} <= '0;
      rdc(OFS_STATUS, 8'h37);
      low_supply_i <= 1'b1;
      repeat (LVF / 2) @(posedge clk_i);
      low_supply_i <= 1'b0;
      wait_lvl(1'b1, 50);
      chk(n, 50);
      low_supply_i <= 1'b1;
      wait_lvl(1'b1, LVF + 5);
      chk(n >= LVF - 1 && n <= LVF + 3, 1);
      repeat (10) @(posedge clk_i);
      low_supply_i <= 1'b0;
      wait_lvl(1'b0, POR + 5);
      chk(n >= POR && n <= POR + 3, 1);
      rdc(OFS_FLAGS, 8'h04);
      rdc(OFS_LVL_SEL, LVL_CODE_3V80);
      rdc(OFS_STATUS, 8'h37);
      wb(1'b1, OFS_FLAGS, 8'h87);
      rdc(OFS_FLAGS, 8'h84);
      chk(idle_sysclk_keep_o, 1);
      wb(1'b1, OFS_FLAGS, 8'h80);
      rdc(OFS_FLAGS, 8'h80);
      wb(1'b1, OFS_WDT_CTRL, 8'h03);
      wait_lvl(1'b1, 40);
      chk(n >= RCD && n <= 3 * RCD + 4, 1);
      wait_lvl(1'b0, POR + 5);
      rdc(OFS_FLAGS, 8'h81);
      rdc(OFS_WDT_CTRL, 8'h53);
      wb(1'b1, OFS_LVL_SEL, 8'h12);
      wait_lvl(1'b1, 40);
      chk(n >= RCD && n <= 3 * RCD + 4, 1);
      wait_lvl(1'b0, POR + 5);
      rdc(OFS_FLAGS, 8'h83);
      rdc(OFS_LVL_SEL, 8'h55);
      chk(lowv_threshold_o, 0);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wait_lvl(1'b0, 200);
      chk(n >= POR && n <= POR + 2, 1);
      rdc(OFS_FLAGS, 8'h00);
      rdc(OFS_STATUS, 8'h04);
      print_verdict();
   end
endmodule // tb
`default_nettype wire
